// file: brsl_pkg.sv
// brsl_pkg: register offsets, field positions, reset values and cycle codes
// for the boot-rom sector lock block.
// assumes config offsets arrive as byte addresses of aligned dwords.
package brsl_pkg;
	// config space offsets of the lock registers
	localparam logic [7:0] BRSL_OFS_LOCK_LO = 8'h80;
	localparam logic [7:0] BRSL_OFS_LOCK_HI = 8'h84;
	localparam logic [7:0] BRSL_OFS_LOCK_SM = 8'h88;
	localparam logic [7:0] BRSL_OFS_CTRL = 8'h8C;
	// reset values
	localparam logic [31:0] BRSL_LOCK_RST = 32'h0000_0000;
	localparam logic [4:0] BRSL_CTRL_RST = 5'h00;
	// nibble field positions
	localparam int BRSL_BIT_READ_BLOCK = 0;
	localparam int BRSL_BIT_WRITE_BLOCK = 1;
	localparam int BRSL_BIT_SMM_ONLY = 2;
	localparam int BRSL_BIT_FREEZE = 3;
	// control register: guard bit above the rest-of-rom nibble
	localparam int BRSL_BIT_REGS_GUARD = 4;
	// set-only bits in every nibble of a 32-bit lock register
	localparam logic [31:0] BRSL_STICKY_MASK = 32'hCCCC_CCCC;
	// special cycle data that moves the system management mode flag
	localparam logic [31:0] BRSL_SPC_SMM_ENTER = 32'h0005_0002;
	localparam logic [31:0] BRSL_SPC_SMM_EXIT = 32'h0006_0002;
	// address windows
	localparam logic [11:0] BRSL_TOP_MB_PREFIX = 12'hFFF;
	localparam logic [15:0] BRSL_SMALL_PREFIX = 16'hFFBF;
	localparam logic [31:0] BRSL_REST_LO = 32'hFFC0_0000;
	localparam logic [31:0] BRSL_REST_HI = 32'hFFEF_FFFF;
	localparam logic [11:0] BRSL_LOW_MB_PREFIX = 12'h000;
	localparam logic [1:0] BRSL_LEGACY_BIOS_SEL = 2'h3;
endpackage

// file: brsl_sector_lock.sv
// brsl_sector_lock: lock nibbles for the boot rom at the top of the 4 GB map,
// the smm flag fed by pci special cycles, and the per-access block decision.
// assumes the pci target decode presents config dword accesses and memory
// cycles as one-cycle requests, synchronous to the pci clock.
module brsl_sector_lock
	import brsl_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	input wire logic cfg_wr_in,
	input wire logic cfg_rd_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	input wire logic spc_valid_in,
	input wire logic [31:0] spc_data_in,
	input wire logic mem_req_in,
	input wire logic mem_write_in,
	input wire logic [31:0] mem_addr_in,
	input wire logic bios_space_in,
	input wire logic rom_write_enable_in,
	output logic [31:0] cfg_rdata_out,
	output logic mem_fwd_out,
	output logic mem_block_out,
	output logic smm_active_out,
	output logic decode_cfg_wr_ok_out
);

	logic [31:0] lock_lo_r, lock_lo_nxt;
	logic [31:0] lock_hi_r, lock_hi_nxt;
	logic [31:0] lock_sm_r, lock_sm_nxt;
	logic [4:0] ctrl_r, ctrl_nxt;
	logic smm_r, smm_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic fwd_r, fwd_nxt;
	logic blk_r, blk_nxt;
	logic dec_ok_r, dec_ok_nxt;
	logic [31:0] eff_addr;
	logic [3:0] sel_nib;
	logic hit;
	logic regs_wr_ok;

	// one nibble write: bits 3:2 only ever set, bits 1:0 guarded by them
	function automatic logic [3:0] brsl_nib_upd(input logic [3:0] old, input logic [3:0] wd, input logic smm);
		logic edit_ok;
		edit_ok = !old[BRSL_BIT_FREEZE] && (!old[BRSL_BIT_SMM_ONLY] || smm);
		brsl_nib_upd[3:2] = old[3:2] | wd[3:2];
		brsl_nib_upd[1:0] = edit_ok ? wd[1:0] : old[1:0];
	endfunction

	// eight nibble updates on one dword, lane by lane
	function automatic logic [31:0] brsl_reg_upd(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic smm);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 8; i++)
		begin
			if (be[i / 2])
			begin
				res[i * 4 +: 4] = brsl_nib_upd(old[i * 4 +: 4], wd[i * 4 +: 4], smm);
			end
		end
		brsl_reg_upd = res;
	endfunction

	// address lookup: remap legacy window, then pick the guarding nibble
	always_comb
	begin
		eff_addr = mem_addr_in;
		sel_nib = 4'h0;
		hit = 1'b0;
		// legacy bios window shadows the top 256 KB of the top megabyte, so locks follow the alias
		if (mem_addr_in[31:20] == BRSL_LOW_MB_PREFIX && mem_addr_in[19:18] == BRSL_LEGACY_BIOS_SEL)
		begin
			eff_addr = {BRSL_TOP_MB_PREFIX, mem_addr_in[19:0]};
		end
		if (eff_addr[31:20] == BRSL_TOP_MB_PREFIX)
		begin
			hit = 1'b1;
			sel_nib = eff_addr[19] ? lock_hi_r[eff_addr[18:16] * 4 +: 4] : lock_lo_r[eff_addr[18:16] * 4 +: 4];
		end
		else if (eff_addr[31:16] == BRSL_SMALL_PREFIX)
		begin
			hit = 1'b1;
			sel_nib = lock_sm_r[eff_addr[15:13] * 4 +: 4];
		end
		else if (eff_addr >= BRSL_REST_LO && eff_addr <= BRSL_REST_HI)
		begin
			hit = 1'b1;
			sel_nib = ctrl_r[3:0];
		end
	end

	// lock register writes, reads and the smm flag
	always_comb
	begin
		lock_lo_nxt = lock_lo_r;
		lock_hi_nxt = lock_hi_r;
		lock_sm_nxt = lock_sm_r;
		ctrl_nxt = ctrl_r;
		smm_nxt = smm_r;
		rdata_nxt = rdata_r;
		regs_wr_ok = !ctrl_r[BRSL_BIT_REGS_GUARD] || smm_r;
		dec_ok_nxt = regs_wr_ok;
		if (cfg_wr_in && regs_wr_ok)
		begin
			case (cfg_addr_in)
				BRSL_OFS_LOCK_LO: lock_lo_nxt = brsl_reg_upd(lock_lo_r, cfg_wdata_in, cfg_be_in, smm_r);
				BRSL_OFS_LOCK_HI: lock_hi_nxt = brsl_reg_upd(lock_hi_r, cfg_wdata_in, cfg_be_in, smm_r);
				BRSL_OFS_LOCK_SM: lock_sm_nxt = brsl_reg_upd(lock_sm_r, cfg_wdata_in, cfg_be_in, smm_r);
				BRSL_OFS_CTRL:
				begin
					if (cfg_be_in[0])
					begin
						ctrl_nxt[3:0] = brsl_nib_upd(ctrl_r[3:0], cfg_wdata_in[3:0], smm_r);
						ctrl_nxt[BRSL_BIT_REGS_GUARD] = ctrl_r[BRSL_BIT_REGS_GUARD] | cfg_wdata_in[4];
					end
				end
				default: ;
			endcase
		end
		if (cfg_rd_in)
		begin
			case (cfg_addr_in)
				BRSL_OFS_LOCK_LO: rdata_nxt = lock_lo_r;
				BRSL_OFS_LOCK_HI: rdata_nxt = lock_hi_r;
				BRSL_OFS_LOCK_SM: rdata_nxt = lock_sm_r;
				BRSL_OFS_CTRL: rdata_nxt = {27'h0, ctrl_r}; // reserved bits read zero
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		// any other special cycle data leaves the flag alone
		if (spc_valid_in && spc_data_in == BRSL_SPC_SMM_ENTER)
		begin
			smm_nxt = 1'b1;
		end
		else if (spc_valid_in && spc_data_in == BRSL_SPC_SMM_EXIT)
		begin
			smm_nxt = 1'b0;
		end
	end

	// access decision, one cycle after the request
	always_comb
	begin
		fwd_nxt = 1'b0;
		blk_nxt = 1'b0;
		if (mem_req_in)
		begin
			if (hit && bios_space_in)
			begin
				if (mem_write_in)
				begin
					blk_nxt = sel_nib[BRSL_BIT_WRITE_BLOCK] || !rom_write_enable_in;
				end
				else
				begin
					blk_nxt = sel_nib[BRSL_BIT_READ_BLOCK];
				end
			end
			fwd_nxt = !blk_nxt;
		end
	end

	// state registers; clock enable low freezes everything
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			lock_lo_r <= BRSL_LOCK_RST;
			lock_hi_r <= BRSL_LOCK_RST;
			lock_sm_r <= BRSL_LOCK_RST;
			ctrl_r <= BRSL_CTRL_RST;
			smm_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			fwd_r <= 1'b0;
			blk_r <= 1'b0;
			dec_ok_r <= 1'b1;
		end
		else if (clk_en_in)
		begin
			lock_lo_r <= lock_lo_nxt;
			lock_hi_r <= lock_hi_nxt;
			lock_sm_r <= lock_sm_nxt;
			ctrl_r <= ctrl_nxt;
			smm_r <= smm_nxt;
			rdata_r <= rdata_nxt;
			fwd_r <= fwd_nxt;
			blk_r <= blk_nxt;
			dec_ok_r <= dec_ok_nxt;
		end
	end

	assign cfg_rdata_out = rdata_r;
	assign mem_fwd_out = fwd_r;
	assign mem_block_out = blk_r;
	assign smm_active_out = smm_r;
	assign decode_cfg_wr_ok_out = dec_ok_r;

	// checks on the flag, the decision and the write protection
	smm_enter_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && spc_valid_in && spc_data_in == BRSL_SPC_SMM_ENTER |=> smm_active_out)
		else $error("smm flag not set by entry cycle");
	smm_exit_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && spc_valid_in && spc_data_in == BRSL_SPC_SMM_EXIT |=> !smm_active_out)
		else $error("smm flag not cleared by exit cycle");
	smm_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		!(clk_en_in && spc_valid_in && (spc_data_in == BRSL_SPC_SMM_ENTER || spc_data_in == BRSL_SPC_SMM_EXIT))
		|=> $stable(smm_active_out))
		else $error("smm flag moved without a matching cycle");
	read_block_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && mem_req_in && !mem_write_in && hit && bios_space_in && sel_nib[0]
		|=> mem_block_out && !mem_fwd_out)
		else $error("locked read was forwarded");
	write_block_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && mem_req_in && mem_write_in && hit && bios_space_in && (sel_nib[1] || !rom_write_enable_in)
		|=> mem_block_out && !mem_fwd_out)
		else $error("locked write was forwarded");
	non_bios_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && mem_req_in && !bios_space_in |=> mem_fwd_out && !mem_block_out)
		else $error("non-bios access was blocked");
	sticky_bits_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		1'b1 |=> ((BRSL_STICKY_MASK & $past(lock_lo_r) & ~lock_lo_r) == 32'h0000_0000)
		&& !($past(ctrl_r[BRSL_BIT_REGS_GUARD]) && !ctrl_r[BRSL_BIT_REGS_GUARD]))
		else $error("set-only lock bit cleared");
	freeze_edit_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && cfg_wr_in && cfg_addr_in == BRSL_OFS_LOCK_LO && lock_lo_r[BRSL_BIT_FREEZE]
		|=> lock_lo_r[1:0] == $past(lock_lo_r[1:0]))
		else $error("frozen lock bits changed");
	regs_guard_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && cfg_wr_in && ctrl_r[BRSL_BIT_REGS_GUARD] && !smm_r
		|=> $stable(lock_hi_r) && $stable(lock_sm_r) && $stable(ctrl_r[3:0]))
		else $error("guarded lock register written outside smm");
	legacy_lock_c: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && mem_req_in && mem_addr_in[31:20] == BRSL_LOW_MB_PREFIX && hit ##1 mem_block_out);
	smm_edit_c: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		smm_r && cfg_wr_in && lock_lo_r[BRSL_BIT_SMM_ONLY]);
	small_sector_c: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		mem_req_in && eff_addr[31:16] == BRSL_SMALL_PREFIX && bios_space_in);

endmodule // brsl_sector_lock

// file: brsl_host_model.sv
// brsl_host_model: pci host side issuing config, special and memory cycles.
// assumes the block samples every request on the rising clock edge.
module brsl_host_model
	import brsl_pkg::*;
(
	input wire logic clk_in,
	input wire logic [31:0] rdata_in,
	input wire logic fwd_in,
	input wire logic block_in,
	output logic cfg_wr_out,
	output logic cfg_rd_out,
	output logic [7:0] addr_out,
	output logic [31:0] wdata_out,
	output logic spc_valid_out,
	output logic mem_req_out,
	output logic mem_write_out,
	output logic [31:0] maddr_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle bus at time zero
	initial
	begin
		{cfg_wr_out, cfg_rd_out, spc_valid_out, mem_req_out, mem_write_out} = 5'h00;
		addr_out = 8'h00;
		wdata_out = 32'h0000_0000;
		maddr_out = 32'h0000_0000;
	end
	// config dword cycle; released lines show inverted values, not stale ones
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		#1;
		cfg_wr_out = wr;
		cfg_rd_out = !wr;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		cfg_wr_out = 1'b0;
		cfg_rd_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
		@(posedge clk_in);
		#1;
		q = rdata_in;
	endtask
	// special cycle data phase, one clock long
	task automatic spc(input logic [31:0] d);
		@(posedge clk_in);
		#1;
		spc_valid_out = 1'b1;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		spc_valid_out = 1'b0;
		wdata_out = ~d;
	endtask
	// memory cycle; answer pulse is read in the cycle after the request
	task automatic mem(input logic w, input logic [31:0] a, output logic [1:0] r);
		@(posedge clk_in);
		#1;
		mem_req_out = 1'b1;
		mem_write_out = w;
		maddr_out = a;
		@(posedge clk_in);
		#1;
		r = {fwd_in, block_in};
		mem_req_out = 1'b0;
		mem_write_out = ~w;
		maddr_out = ~a;
	endtask
endmodule // brsl_host_model

// file: tb.sv
// tb: self-checking bench for the boot-rom sector lock block.
// assumes the host model drives all cycles; clock enable held high except during one special cycle.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import brsl_pkg::*;
	localparam logic [1:0] FWD = 2'h2;
	localparam logic [1:0] BLK = 2'h1;
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic bios = 1'b1;
	logic rwe = 1'b1;
	logic cen = 1'b1;
	logic [3:0] be = 4'hF;
	logic cw, cr, sv, mr, mw, fwd, blk, smm, dok;
	logic [7:0] ca;
	logic [31:0] wd, ma, rd, q;
	logic [1:0] r;
	int fail_count = 0;
	int checks_done = 0;
	// 250 MHz clock
	always #2 core_clk_in = ~core_clk_in;
	brsl_host_model u_host (.clk_in(core_clk_in), .rdata_in(rd), .fwd_in(fwd), .block_in(blk),
		.cfg_wr_out(cw), .cfg_rd_out(cr), .addr_out(ca), .wdata_out(wd), .spc_valid_out(sv),
		.mem_req_out(mr), .mem_write_out(mw), .maddr_out(ma));
	brsl_sector_lock u_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .clk_en_in(cen),
		.cfg_wr_in(cw), .cfg_rd_in(cr), .cfg_addr_in(ca), .cfg_be_in(be), .cfg_wdata_in(wd),
		.spc_valid_in(sv), .spc_data_in(wd), .mem_req_in(mr), .mem_write_in(mw), .mem_addr_in(ma),
		.bios_space_in(bios), .rom_write_enable_in(rwe), .cfg_rdata_out(rd), .mem_fwd_out(fwd),
		.mem_block_out(blk), .smm_active_out(smm), .decode_cfg_wr_ok_out(dok));
	// compare and count
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.cfg(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		u_host.cfg(1'b0, a, 32'h0000_0000, q);
		chk(e, q);
	endtask
	task automatic mc(input logic w, input logic [31:0] a, input logic [1:0] e);
		u_host.mem(w, a, r);
		chk({30'h0, e}, {30'h0, r});
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// main sequence; no wait here is open-ended, all latencies are fixed
	initial
	begin
		repeat (4) @(posedge core_clk_in);
		#1;
		rst_b_in = 1'b1;
		for (int i = 0; i < 4; i++)
			rdc(BRSL_OFS_LOCK_LO + 8'(4 * i), BRSL_LOCK_RST);
		chk({30'h0, smm, dok}, 32'h0000_0001);
		wr(8'h90, 32'hFFFF_FFFF);
		rdc(8'h90, 32'h0000_0000);
		wr(BRSL_OFS_LOCK_LO, 32'h0000_1000);
		wr(BRSL_OFS_LOCK_HI, 32'h2001_0000);
		mc(1'b0, 32'hFFF3_0000, BLK);
		mc(1'b1, 32'hFFF3_0000, FWD);
		mc(1'b0, 32'hFFF2_0000, FWD);
		mc(1'b1, 32'hFFFF_0000, BLK);
		mc(1'b0, 32'h000C_0000, BLK);
		bios = 1'b0;
		mc(1'b0, 32'hFFF3_0000, FWD);
		bios = 1'b1;
		rwe = 1'b0;
		mc(1'b1, 32'hFFF2_0000, BLK);
		rwe = 1'b1;
		wr(BRSL_OFS_LOCK_SM, 32'h0000_0010);
		mc(1'b0, 32'hFFBF_3000, BLK);
		mc(1'b0, 32'hFFBF_1000, FWD);
		// lane 1 only: nibbles 2 and 3 change, lane 0 keeps its window lock
		be = 4'h2;
		wr(BRSL_OFS_LOCK_SM, 32'h0000_1111);
		be = 4'hF;
		rdc(BRSL_OFS_LOCK_SM, 32'h0000_1110);
		wr(BRSL_OFS_CTRL, 32'h0000_0002);
		mc(1'b1, 32'hFFC0_0000, BLK);
		mc(1'b1, 32'hFFEF_FFFF, BLK);
		mc(1'b1, 32'hFFBE_0000, FWD);
		// smm-only bit set in nibble 0, nibble 3 cleared; bits 1:0 edits need smm
		wr(BRSL_OFS_LOCK_LO, 32'h0000_1004);
		wr(BRSL_OFS_LOCK_LO, 32'h0000_0007);
		rdc(BRSL_OFS_LOCK_LO, 32'h0000_0004);
		// clock enable low: an entry cycle in that clock is not taken
		cen = 1'b0;
		u_host.spc(BRSL_SPC_SMM_ENTER);
		chk({31'h0, smm}, 32'h0000_0000);
		cen = 1'b1;
		u_host.spc(BRSL_SPC_SMM_ENTER);
		chk({31'h0, smm}, 32'h0000_0001);
		wr(BRSL_OFS_LOCK_LO, 32'h0000_0003);
		rdc(BRSL_OFS_LOCK_LO, 32'h0000_0007);
		u_host.spc(32'h0007_0002);
		chk({31'h0, smm}, 32'h0000_0001);
		wr(BRSL_OFS_LOCK_LO, 32'h0000_000B);
		wr(BRSL_OFS_LOCK_LO, 32'h0000_0000);
		rdc(BRSL_OFS_LOCK_LO, 32'h0000_000F);
		u_host.spc(BRSL_SPC_SMM_EXIT);
		chk({31'h0, smm}, 32'h0000_0000);
		// register guard: lock writes only inside smm
		wr(BRSL_OFS_CTRL, 32'h0000_0012);
		rdc(BRSL_OFS_CTRL, 32'h0000_0012);
		chk({31'h0, dok}, 32'h0000_0000);
		wr(BRSL_OFS_LOCK_HI, 32'h0000_0000);
		rdc(BRSL_OFS_LOCK_HI, 32'h2001_0000);
		u_host.spc(BRSL_SPC_SMM_ENTER);
		wr(BRSL_OFS_LOCK_HI, 32'h0000_0000);
		chk({31'h0, dok}, 32'h0000_0001);
		rdc(BRSL_OFS_LOCK_HI, 32'h0000_0000);
		wr(BRSL_OFS_CTRL, 32'h0000_0000);
		rdc(BRSL_OFS_CTRL, 32'h0000_0010);
		summarize();
	end
endmodule // tb
